// ===== common/mpsc_pkg.sv
// Summary of operation
// RULE_01: Run state releases module reset and keeps module clock running.
// RULE_02: Clock-gated state releases reset and stops clock; module keeps its state.
// RULE_03: Reset-with-clock state asserts module reset with clock running.
// RULE_04: Reset-clock-gated state asserts reset, stops clock; default after power-on (here module 39 resets to the run state instead).
// RULE_05: Module reset returns all module hardware to default condition.
// RULE_06: Single power domain always reports ON; software never requests OFF.
// RULE_07: Requested state codes: 0 reset-gated, 1 reset-clocked, 2 gated, 3 run.
// RULE_08: Staged requested states change nothing until launch command is written.
// RULE_09: Launch bit 0 starts transitions; busy bit reads 1 until all settled.
// RULE_10: Software polls busy bit to 0 before staging or launching again.
// RULE_11: Writing 0 to core local reset bit asserts it, 1 releases it.
// RULE_12: Local reset resets only the core; its memories stay accessible.
// RULE_13: Module reset dominates local reset in either reset-asserted state.
// RULE_14: Local reset release in run state lets core execute immediately.
// RULE_15: Emulation overrides and their events apply only to module 39.
// RULE_16: Inhibit-sleep refuses software requests that leave the run state.
// RULE_17: Force-active places the module in run state regardless of request.
// RULE_18: Assert-reset holds local reset; wait-reset extends it after release.
// RULE_19: Block-reset ignores software changes to local and module reset.
// RULE_20: Removing an override immediately applies software-programmed states.
// RULE_21: State event set by inhibit-sleep refusal or force-active on non-running module.
// RULE_22: Reset event set by assert-reset hold, wait-reset, or block-reset refusal.
// RULE_23: Interrupt raised when any enabled event becomes active.
// RULE_24: Writing 1 to bit 39 of error clear register clears core pending status (here bit 7, ERR_PEND_BIT).
// RULE_25: Writing 1 to reevaluate re-raises interrupt if any status still set (here only a status whose interrupt enable is set).
// RULE_26: Busy bit is set in the same cycle the launch command is accepted.
package mpsc_pkg;

	localparam int unsigned NUM_MODULES   = 41;
	localparam int unsigned CPU_MODULE    = 39;
	localparam int unsigned ADDR_W        = 12;

	localparam logic [11:0] IRQ_EVAL_OFS   = 12'h018;
	localparam logic [11:0] ERR_PEND_OFS   = 12'h044;
	localparam logic [11:0] ERR_CLEAR_OFS  = 12'h054;
	localparam logic [11:0] CMD_OFS        = 12'h120;
	localparam logic [11:0] STATUS_OFS     = 12'h128;
	localparam logic [11:0] DOM_STAT_OFS   = 12'h200;
	localparam logic [11:0] DOM_CTRL_OFS   = 12'h300;
	localparam logic [11:0] MOD_STAT_BASE  = 12'h800;
	localparam logic [11:0] MOD_CTRL_BASE  = 12'hA00;
	localparam logic [11:0] MOD_SPAN       = 12'h0A0;

	localparam int unsigned ERR_PEND_BIT   = 7;
	localparam int unsigned FLD_STATE_LO   = 0;
	localparam int unsigned FLD_CPU_LOCAL_RESET_N       = 8;
	localparam int unsigned FLD_EMUIE_ST   = 9;
	localparam int unsigned FLD_EMUIE_RST  = 10;
	localparam int unsigned FLD_EV_ST      = 16;
	localparam int unsigned FLD_EV_RST     = 17;
	localparam int unsigned FLD_MRST_STAT  = 12;
	localparam int unsigned FLD_MCLK_STAT  = 13;

	// Settling latency of a launched transition, in clock cycles.
	localparam int unsigned SETTLE_CYCLES  = 4;
	localparam int unsigned WAIT_RST_NS    = 1000;
	localparam int unsigned CLK_NS         = 20;
	localparam int unsigned WAIT_RST_CYC   = (WAIT_RST_NS + CLK_NS - 1) / CLK_NS;

	localparam logic [1:0]  RST_STATE      = 2'h0;
	localparam logic [1:0]  CPU_RST_STATE  = 2'h3;
	localparam logic [1:0]  DOM_ON         = 2'h1;

	typedef enum logic [1:0]
	{
		MST_RESET_GATED = 2'h0,
		MST_RESET_CLK   = 2'h1,
		MST_GATED       = 2'h2,
		MST_RUN         = 2'h3
	} mpsc_mstate_type;

	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'b01,
		SEQ_BUSY = 2'b10
	} mpsc_seq_type;

	typedef struct packed
	{
		logic inhibit_sleep;
		logic force_active;
		logic assert_reset;
		logic wait_reset;
		logic block_reset;
	} mpsc_emu_type;

endpackage

// ===== verilog/mpsc_top.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ns
module mpsc_top
	import mpsc_pkg::*;
#(
	parameter int unsigned N_MOD = NUM_MODULES
)
(
	input  wire logic               MCLK,
	input  wire logic               RST_B,
	input  wire logic               CLK_EN,
	input  wire logic [11:0]        ADDR,
	input  wire logic [31:0]        WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic      [31:0]        RDATA,
	input  wire mpsc_emu_type       EMU,
	output logic      [N_MOD-1:0]   MOD_RST_B,
	output logic      [N_MOD-1:0]   MOD_CLK_EN,
	output logic                    CPU_CPU_LOCAL_RESET_N_B,
	output logic                    IRQ
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire        mod_ctrl_hit = (ADDR >= MOD_CTRL_BASE) && (ADDR < MOD_CTRL_BASE + MOD_SPAN);
	wire        mod_stat_hit = (ADDR >= MOD_STAT_BASE) && (ADDR < MOD_STAT_BASE + MOD_SPAN);
	wire [11:0] ctrl_rel     = ADDR - MOD_CTRL_BASE;
	wire [11:0] stat_rel     = ADDR - MOD_STAT_BASE;
	wire [5:0]  ctrl_idx     = ctrl_rel[7:2];
	wire [5:0]  stat_idx     = stat_rel[7:2];
	wire        wr_cmd       = CLK_EN && WR && (ADDR == CMD_OFS);
	wire        wr_clear     = CLK_EN && WR && (ADDR == ERR_CLEAR_OFS) && WDATA[ERR_PEND_BIT];
	wire        wr_eval      = CLK_EN && WR && (ADDR == IRQ_EVAL_OFS) && WDATA[0];
	wire        wr_mod       = CLK_EN && WR && mod_ctrl_hit;

	// ****************************************************************
	// Registers and state
	// ****************************************************************
	logic [1:0]        next_reg [N_MOD];
	logic [1:0]        act_reg  [N_MOD];
	logic              cpu_local_reset_n_sw_reg;
	logic              ie_st_reg;
	logic              ie_rst_reg;
	logic              ev_st_reg;
	logic              ev_rst_reg;
	logic              irq_reg;
	logic [7:0]        settle_reg;
	logic [15:0]       wait_cnt_reg;
	logic              cpu_local_reset_n_out_reg;
	mpsc_emu_type      emu_d_reg;
	mpsc_seq_type      seq_reg;
	logic [31:0]       rdata_reg;

	// A launch is accepted only while idle; a launch during busy is dropped.
	wire launch = wr_cmd && WDATA[0] && (seq_reg == SEQ_IDLE);
	wire done   = (seq_reg == SEQ_BUSY) && (settle_reg == 8'h00);

	// Removing any override reapplies the programmed states at once.
	wire emu_removed = |(emu_d_reg & ~EMU); // RULE_20

	// Effective target for the core module after emulation overrides.
	logic [1:0] cpu_target;
	always_comb
	begin
		cpu_target = next_reg[CPU_MODULE];
		if (EMU.force_active) // RULE_17
			cpu_target = MST_RUN;
		else if (EMU.inhibit_sleep && act_reg[CPU_MODULE] == MST_RUN) // RULE_16
			cpu_target = MST_RUN;
		else if (EMU.block_reset && !act_reg[CPU_MODULE][1]) // RULE_19
			cpu_target = act_reg[CPU_MODULE];
		else if (EMU.block_reset && !next_reg[CPU_MODULE][1]) // RULE_19
			cpu_target = act_reg[CPU_MODULE];
	end

	wire cpu_apply = done || emu_removed || EMU.force_active; // RULE_20

	// ****************************************************************
	// Events
	// ****************************************************************
	wire st_event  = (EMU.inhibit_sleep && act_reg[CPU_MODULE] == MST_RUN &&
	                  next_reg[CPU_MODULE] != MST_RUN && done) ||
	                 (EMU.force_active && act_reg[CPU_MODULE] != MST_RUN); // RULE_21
	wire cpu_local_reset_n_wr   = wr_mod && (ctrl_idx == 6'(CPU_MODULE));
	wire rst_event = (EMU.assert_reset && cpu_local_reset_n_sw_reg) ||
	                 (EMU.wait_reset) ||
	                 (EMU.block_reset && cpu_local_reset_n_wr &&
	                  WDATA[FLD_CPU_LOCAL_RESET_N] != cpu_local_reset_n_sw_reg); // RULE_22

	// ****************************************************************
	// Sequencer and module state
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < N_MOD; g++)
		begin : gen_mod
			always_ff @(posedge MCLK or negedge RST_B)
			begin
				if (!RST_B)
				begin
					next_reg[g] <= (g == CPU_MODULE) ? CPU_RST_STATE : RST_STATE; // RULE_04
					act_reg[g]  <= (g == CPU_MODULE) ? CPU_RST_STATE : RST_STATE;
				end
				else if (CLK_EN)
				begin
					if (wr_mod && ctrl_idx == 6'(g))
						next_reg[g] <= WDATA[1:0]; // RULE_07 RULE_08
					if (g == CPU_MODULE)
					begin
						if (cpu_apply)
							act_reg[g] <= cpu_target; // RULE_15
					end
					else if (done)
						act_reg[g] <= next_reg[g]; // RULE_08
				end
			end
			assign MOD_RST_B[g]  = act_reg[g][1]; // RULE_01 RULE_03 RULE_05
			assign MOD_CLK_EN[g] = act_reg[g][0]; // RULE_02
		end
	endgenerate

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			seq_reg    <= SEQ_IDLE;
			settle_reg <= 8'h00;
		end
		else if (CLK_EN)
		begin
			case (seq_reg)
				SEQ_IDLE:
					if (launch)
					begin
						seq_reg    <= SEQ_BUSY; // RULE_09
						settle_reg <= 8'(SETTLE_CYCLES - 1);
					end
				SEQ_BUSY:
					if (settle_reg == 8'h00)
						seq_reg <= SEQ_IDLE; // RULE_09
					else
						settle_reg <= settle_reg - 8'h01;
				default:
					seq_reg <= SEQ_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Core local reset and emulation
	// ****************************************************************
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			cpu_local_reset_n_sw_reg  <= 1'b1;
			ie_st_reg    <= 1'b0;
			ie_rst_reg   <= 1'b0;
			emu_d_reg    <= '0;
			wait_cnt_reg <= 16'h0000;
			cpu_local_reset_n_out_reg <= 1'b1;
		end
		else if (CLK_EN)
		begin
			emu_d_reg <= EMU;
			if (cpu_local_reset_n_wr)
			begin
				if (!EMU.block_reset)
					cpu_local_reset_n_sw_reg <= WDATA[FLD_CPU_LOCAL_RESET_N]; // RULE_11 RULE_19
				ie_st_reg  <= WDATA[FLD_EMUIE_ST];
				ie_rst_reg <= WDATA[FLD_EMUIE_RST];
			end
			// Wait-reset stretches the release by a fixed count after software lets go.
			// Dropping the override cuts the stretch short, so software's value applies at once.
			if (!EMU.wait_reset)
				wait_cnt_reg <= 16'h0000; // RULE_20
			else if (cpu_local_reset_n_wr && WDATA[FLD_CPU_LOCAL_RESET_N] && !cpu_local_reset_n_sw_reg)
				wait_cnt_reg <= 16'(WAIT_RST_CYC); // RULE_18
			else if (wait_cnt_reg != 16'h0000)
				wait_cnt_reg <= wait_cnt_reg - 16'h0001;
			cpu_local_reset_n_out_reg <= cpu_local_reset_n_sw_reg && !EMU.assert_reset &&
			                (wait_cnt_reg == 16'h0000); // RULE_18
		end
	end

	// Module reset dominates; release in run state starts the core at once.
	assign CPU_CPU_LOCAL_RESET_N_B = cpu_local_reset_n_out_reg && act_reg[CPU_MODULE][1]; // RULE_12 RULE_13 RULE_14

	// ****************************************************************
	// Status events and interrupt
	// ****************************************************************
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ev_st_reg  <= 1'b0;
			ev_rst_reg <= 1'b0;
			irq_reg    <= 1'b0;
		end
		else if (CLK_EN)
		begin
			// A new event wins over a clear in the same cycle.
			ev_st_reg  <= st_event  | (ev_st_reg  & ~wr_clear); // RULE_21 RULE_24
			ev_rst_reg <= rst_event | (ev_rst_reg & ~wr_clear); // RULE_22 RULE_24
			if ((st_event && ie_st_reg) || (rst_event && ie_rst_reg))
				irq_reg <= 1'b1; // RULE_23
			else if (wr_eval)
				irq_reg <= (ev_st_reg && ie_st_reg) || (ev_rst_reg && ie_rst_reg); // RULE_25
			else if (wr_clear)
				irq_reg <= 1'b0;
		end
	end
	assign IRQ = irq_reg;

	// ****************************************************************
	// Read path
	// ****************************************************************
	wire        pend     = ev_st_reg | ev_rst_reg;
	wire [1:0]  cs_act   = act_reg[CPU_MODULE];
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (ADDR == STATUS_OFS)
			rd_mux[0] = (seq_reg == SEQ_BUSY); // RULE_26
		else if (ADDR == ERR_PEND_OFS)
			rd_mux[ERR_PEND_BIT] = pend;
		else if (ADDR == DOM_STAT_OFS || ADDR == DOM_CTRL_OFS)
			rd_mux[1:0] = DOM_ON; // RULE_06
		else if (mod_ctrl_hit && ctrl_idx < 6'(N_MOD))
		begin
			rd_mux[1:0] = next_reg[ctrl_idx];
			if (ctrl_idx == 6'(CPU_MODULE))
			begin
				rd_mux[FLD_CPU_LOCAL_RESET_N]      = cpu_local_reset_n_sw_reg;
				rd_mux[FLD_EMUIE_ST]  = ie_st_reg;
				rd_mux[FLD_EMUIE_RST] = ie_rst_reg;
			end
		end
		else if (mod_stat_hit && stat_idx < 6'(N_MOD))
		begin
			rd_mux[1:0]           = act_reg[stat_idx];
			rd_mux[FLD_MRST_STAT] = act_reg[stat_idx][1];
			rd_mux[FLD_MCLK_STAT] = act_reg[stat_idx][0];
			if (stat_idx == 6'(CPU_MODULE))
			begin
				rd_mux[FLD_CPU_LOCAL_RESET_N]   = CPU_CPU_LOCAL_RESET_N_B;
				rd_mux[FLD_EV_ST]  = ev_st_reg;
				rd_mux[FLD_EV_RST] = ev_rst_reg;
			end
		end
		if (cs_act == 2'h0 && ADDR == 12'hFFF)
			rd_mux = 32'h0000_0000;
	end

	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
			rdata_reg <= 32'h0000_0000;
		else if (CLK_EN)
			rdata_reg <= RD ? rd_mux : 32'h0000_0000;
	end
	assign RDATA = rdata_reg;

endmodule

// ===== test/mpsc_sva.sv
`timescale 1ns/1ns
module mpsc_sva
	import mpsc_pkg::*;
#(
	parameter int unsigned N_MOD = NUM_MODULES
)
(
	input wire logic                MCLK,
	input wire logic                RST_B,
	input wire logic                CLK_EN,
	input wire logic [11:0]         ADDR,
	input wire logic [31:0]         WDATA,
	input wire logic                WR,
	input wire logic                RD,
	input wire logic [31:0]         RDATA,
	input wire mpsc_emu_type        EMU,
	input wire logic [N_MOD-1:0]    MOD_RST_B,
	input wire logic [N_MOD-1:0]    MOD_CLK_EN,
	input wire logic                CPU_CPU_LOCAL_RESET_N_B
);
	localparam logic [N_MOD-1:0] CPU_BIT = {{(N_MOD-1){1'b0}}, 1'b1} << CPU_MODULE;
	logic [3:0]  go_age;
	wire         go_wr = WR && CLK_EN && ADDR == CMD_OFS && WDATA[0];
	wire         cpu_on = MOD_RST_B[CPU_MODULE] && MOD_CLK_EN[CPU_MODULE];
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	// ****************************************
	// Age of the last launch, saturating.
	// ****************************************
	always_ff @(posedge MCLK or negedge RST_B)
		if (!RST_B)
			go_age <= 4'hF;
		else if (go_wr)
			go_age <= 4'h0;
		else if (go_age != 4'hF && CLK_EN)
			go_age <= go_age + 4'h1;
	property p_busy; go_wr ##1 (RD && CLK_EN && ADDR == STATUS_OFS) |=> RDATA[0]; endproperty
	a_busy: assert property (p_busy) else $error("busy not seen after launch");
	property p_staged; $changed(MOD_RST_B & ~CPU_BIT) || $changed(MOD_CLK_EN & ~CPU_BIT)
		|-> go_age < 4'h8; endproperty
	a_staged: assert property (p_staged) else $error("state moved without launch");
	property p_dom; $past(RD && CLK_EN && ADDR == DOM_STAT_OFS) |-> RDATA == 32'h1; endproperty
	a_dom: assert property (p_dom) else $error("domain not on");
	property p_dominate; !MOD_RST_B[CPU_MODULE] && $past(!MOD_RST_B[CPU_MODULE]) |-> !CPU_CPU_LOCAL_RESET_N_B;
	endproperty
	a_dominate: assert property (p_dominate) else $error("local reset free in reset");
	property p_force; EMU.force_active && $past(EMU.force_active && !EMU.block_reset && CLK_EN)
		&& !EMU.block_reset |-> cpu_on; endproperty
	a_force: assert property (p_force) else $error("force active ignored");
	property p_hold; EMU.assert_reset && $past(EMU.assert_reset && CLK_EN) |-> !CPU_CPU_LOCAL_RESET_N_B;
	endproperty
	a_hold: assert property (p_hold) else $error("assert reset ignored");
	property p_block; EMU.block_reset && !EMU.wait_reset && $stable(EMU)
		&& EMU == $past(EMU, 2) && EMU == $past(EMU, 3)
		|-> $stable(CPU_CPU_LOCAL_RESET_N_B) && $stable(MOD_RST_B[CPU_MODULE]); endproperty
	a_block: assert property (p_block) else $error("reset moved while blocked");
	property p_inhibit; EMU.inhibit_sleep && $past(EMU.inhibit_sleep && cpu_on) |-> cpu_on;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("core left run state");
endmodule
bind mpsc_top mpsc_sva #(.N_MOD(N_MOD)) i_sva (.MCLK(MCLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EMU(EMU),
	.MOD_RST_B(MOD_RST_B), .MOD_CLK_EN(MOD_CLK_EN), .CPU_CPU_LOCAL_RESET_N_B(CPU_CPU_LOCAL_RESET_N_B));

// ===== test/mpsc_mod_model.sv
`timescale 1ns/1ns
module mpsc_mod_model
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        clk_en,
	output logic     [7:0]  cnt
);
	// A static module: a stopped clock keeps the count, reset clears it.
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			cnt <= 8'h00;
		else if (clk_en)
			cnt <= cnt + 8'h01;
endmodule

// ===== test/mpsc_tb_top.sv
`timescale 1ns/1ns
module mpsc_tb_top;
	import mpsc_pkg::*;
	logic mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, d;
	mpsc_emu_type emu = '0;
	logic [40:0] mod_rst_b, mod_clk_en;
	logic cpu_cpu_local_reset_n_b, irq;
	logic [7:0] cnt, cnt0;
	logic [1:0] ps = 2'h0;
	int miscompares = 0, comparisons = 0, seed = 82, cyc = 0, m;
	localparam logic [11:0] C39 = MOD_CTRL_BASE + 12'(CPU_MODULE * 4);
	mpsc_top i_dut (.MCLK(mclk), .RST_B(rst_b), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .EMU(emu), .MOD_RST_B(mod_rst_b),
		.MOD_CLK_EN(mod_clk_en), .CPU_CPU_LOCAL_RESET_N_B(cpu_cpu_local_reset_n_b), .IRQ(irq));
	mpsc_mod_model i_mod (.clk(mclk), .rst_b(mod_rst_b[m]), .clk_en(mod_clk_en[m]), .cnt(cnt));
	always #10 mclk = ~mclk;
	always @(posedge mclk)
		if (cyc++ == 5000)
			results(1'b1);
	task automatic results(input bit hang);
		miscompares += hang;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wreg(input logic [11:0] a, input logic [31:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [11:0] a, output logic [31:0] v);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// Launch, then read the busy flag in the very next cycle and poll it down.
	task automatic launch;
		int n;
		wreg(CMD_OFS, 32'h1);
		rd <= 1'b1;
		addr <= STATUS_OFS;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk("busy", 1, rdata[0]);
		n = 0;
		do
		begin
			rreg(STATUS_OFS, d);
			n++;
		end
		while (d[0] !== 1'b0 && n < 50);
		chk("settled", 0, d[0]);
	endtask
	task automatic ctl39(input logic [1:0] st, input logic lr);
		wreg(C39, {21'h0, 2'b11, lr, 6'h0, st});
		repeat (3) @(posedge mclk);
		#1;
	endtask
	initial
	begin
		m = $unsigned($random(seed)) % 39;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		#1 chk("mrst", 64'h1 << CPU_MODULE, mod_rst_b);
		chk("mclk", 64'h1 << CPU_MODULE, mod_clk_en);
		rreg(DOM_STAT_OFS, d);
		chk("dom", 1, d);
		rreg(12'h004, d);
		chk("unmapped", 0, d);
		for (int s = 3; s >= 0; s--)
		begin
			wreg(MOD_CTRL_BASE + 12'(m * 4), 32'(s) | ($random(seed) & 32'hFFFFF0FC));
			repeat (6) @(posedge mclk);
			#1 chk("staged", ps, {mod_rst_b[m], mod_clk_en[m]});
			launch();
			cnt0 = cnt;
			repeat (3) @(posedge mclk);
			#1 chk("state", s, {mod_rst_b[m], mod_clk_en[m]});
			chk("count", s == 3 ? 8'(cnt0 + 8'h3) : (s == 2 ? cnt0 : 8'h0), cnt);
			rreg(MOD_STAT_BASE + 12'(m * 4), d);
			chk("status", s, d[1:0]);
			ps = 2'(s);
		end
		// A launch taken just before the clock enable drops must wait out the frozen time.
		wreg(MOD_CTRL_BASE + 12'(m * 4), 32'h3);
		wreg(CMD_OFS, 32'h1);
		clk_en <= 1'b0;
		repeat (10) @(posedge mclk);
		#1 chk("frozen", 0, {mod_rst_b[m], mod_clk_en[m]});
		@(posedge mclk) clk_en <= 1'b1;
		rreg(STATUS_OFS, d);
		chk("held", 1, d[0]);
		repeat (6) @(posedge mclk);
		#1 chk("thawed", 3, {mod_rst_b[m], mod_clk_en[m]});
		ctl39(2'h3, 1'b0);
		chk("cpu_local_reset_n", 0, cpu_cpu_local_reset_n_b);
		ctl39(2'h3, 1'b1);
		chk("cpu_local_reset_n", 1, cpu_cpu_local_reset_n_b);
		ctl39(2'h1, 1'b0);
		launch();
		ctl39(2'h1, 1'b1);
		chk("cpu_local_reset_n", 0, cpu_cpu_local_reset_n_b);
		ctl39(2'h3, 1'b1);
		launch();
		@(posedge mclk) emu.inhibit_sleep <= 1'b1;
		wreg(C39, 32'h0000_0100);
		launch();
		chk("inhibit", 3, {mod_rst_b[CPU_MODULE], mod_clk_en[CPU_MODULE]});
		chk("irqoff", 0, irq);
		ctl39(2'h0, 1'b1);
		wreg(IRQ_EVAL_OFS, 32'h0);
		#1 chk("eval0", 0, irq);
		wreg(IRQ_EVAL_OFS, 32'h1);
		#1 chk("irq", 1, irq);
		rreg(MOD_STAT_BASE + 12'(CPU_MODULE * 4), d);
		chk("stev", 1, d[16]);
		rreg(ERR_PEND_OFS, d);
		chk("pend", 1, d[7]);
		wreg(ERR_CLEAR_OFS, 32'h80);
		#1 chk("irqclr", 0, irq);
		rreg(ERR_PEND_OFS, d);
		chk("clear", 0, d[7]);
		@(posedge mclk) emu.inhibit_sleep <= 1'b0;
		ctl39(2'h0, 1'b1);
		chk("release", 0, {mod_rst_b[CPU_MODULE], mod_clk_en[CPU_MODULE]});
		@(posedge mclk) emu.force_active <= 1'b1;
		ctl39(2'h0, 1'b1);
		chk("force", 3, {mod_rst_b[CPU_MODULE], mod_clk_en[CPU_MODULE]});
		rreg(MOD_STAT_BASE + 12'(CPU_MODULE * 4), d);
		chk("fev", 1, d[16]);
		@(posedge mclk) emu.force_active <= 1'b0;
		ctl39(2'h3, 1'b1);
		launch();
		@(posedge mclk) emu.assert_reset <= 1'b1;
		ctl39(2'h3, 1'b1);
		chk("assert", 0, cpu_cpu_local_reset_n_b);
		rreg(MOD_STAT_BASE + 12'(CPU_MODULE * 4), d);
		chk("rsev", 1, d[17]);
		@(posedge mclk) emu.assert_reset <= 1'b0;
		ctl39(2'h3, 1'b0);
		@(posedge mclk) emu.wait_reset <= 1'b1;
		ctl39(2'h3, 1'b1);
		repeat (WAIT_RST_CYC - 10) @(posedge mclk);
		#1 chk("wait", 0, cpu_cpu_local_reset_n_b);
		@(posedge mclk) emu.wait_reset <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk("waitend", 1, cpu_cpu_local_reset_n_b);
		@(posedge mclk) emu.block_reset <= 1'b1;
		ctl39(2'h3, 1'b0);
		chk("block", 1, cpu_cpu_local_reset_n_b);
		@(posedge mclk) emu.block_reset <= 1'b0;
		ctl39(2'h3, 1'b0);
		chk("unblock", 0, cpu_cpu_local_reset_n_b);
		results(1'b0);
	end
endmodule
